// ==== src/port_phy_link_config_preload.sv ====
/*
  Boot-time loader: takes words read from the configuration memory and
  scatters their fields into per-port link and physical-layer configuration,
  with an APB slave for restart and readback.
  Assumes the memory reader runs on clk, presents one word per valid cycle and
  pulses load_end after its last word.
*/
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "preload_regs.svh"
module port_phy_link_config_preload
#(
  parameter int NUM_PORTS = 4,
  parameter int NUM_LINK_PORTS = 2
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire preload_pkg::cfg_word_s word_in,
  input wire logic load_end,
  output logic load_start,
  output logic load_done,
  output preload_pkg::phy_cfg_s [NUM_PORTS-1:0] phy_cfg,
  output preload_pkg::link_cfg_s [NUM_LINK_PORTS-1:0] link_cfg,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);

  typedef struct packed {
    preload_pkg::load_state_e st;
    logic [NUM_LINK_PORTS-1:0][15:0] link_word;
    logic [7:0] words_seen;
    logic load_start;
    logic load_done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s s;
  state_s next_s;
  logic rst_s;
  logic loading;
  logic clear_fields;
  logic reload_wr;
  logic [NUM_PORTS-1:0] phy_wr;

  reset_release u_reset_release
  (
    .clk(clk),
    .rst_n(rst_n),
    .rst_n_sync(rst_s)
  );

  assign loading = (s.st == preload_pkg::ST_LOAD);
  // restart returns every field to its default before the memory is read again
  assign clear_fields = (s.st == preload_pkg::ST_START);

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      assign phy_wr[p] = loading && word_in.valid
        && word_in.addr == 8'(`WADDR_PHY_P0 + `WADDR_PHY_STEP * p);

      port_phy_fields #(
        .RST_WORD(`PHY_WORD_RST)
      ) u_fields
      (
        .clk(clk),
        .rst_n(rst_s),
        .clear(clear_fields),
        .wr_en(phy_wr[p]),
        .wr_data(word_in.data),
        .cfg(phy_cfg[p])
      );
    end
    for (p = 0; p < NUM_LINK_PORTS; p++)
    begin : g_link
      assign link_cfg[p].ltssm_ctl = s.link_word[p][`SW_LTSSM];
      assign link_cfg[p].l1_power_mgmt_option = s.link_word[p][`SW_L1_OPT];
      assign link_cfg[p].l1_power_mgmt_off = s.link_word[p][`SW_L1_OFF];
      assign link_cfg[p].clkreq_ctl = s.link_word[p][`SW_CLKREQ];
    end
  endgenerate

  function automatic logic [31:0] img78(input preload_pkg::phy_cfg_s c);
    logic [31:0] v;
    v = '0;
    v[`D78_FTS] = c.fts;
    v[`D78_SCR] = c.scrambler;
    v[`D78_L0S] = c.l0s;
    v[`D78_SPD_SEL] = c.speed_sel;
    v[`D78_SPD_EN] = c.speed_en;
    return v;
  endfunction

  function automatic logic [31:0] img68(input preload_pkg::phy_cfg_s c);
    logic [31:0] v;
    v = '0;
    v[`D68_DESKEW] = c.deskew;
    return v;
  endfunction

  function automatic logic [31:0] img98(input preload_pkg::link_cfg_s c);
    logic [31:0] v;
    v = '0;
    v[`D98_L1_OPT] = c.l1_power_mgmt_option;
    v[`D98_L1_OFF] = c.l1_power_mgmt_off;
    v[`D98_CLKREQ] = c.clkreq_ctl;
    return v;
  endfunction

  function automatic logic [31:0] img33c(input preload_pkg::link_cfg_s c);
    logic [31:0] v;
    v = '0;
    v[`D33C_LTSSM] = c.ltssm_ctl;
    return v;
  endfunction

  // a write takes effect on the edge that completes the access
  assign reload_wr = psel && penable && s.pready && pwrite && !s.pslverr
    && paddr[11:2] == `APB_CTRL >> 2 && pwdata[`CTRL_RELOAD];

  always_comb
  begin
    logic [31:0] rd;
    logic err;
    logic [1:0] idx;
    rd = '0;
    err = 1'h0;
    idx = paddr[3:2];
    next_s = s;
    next_s.load_start = 1'h0;

    unique case (s.st)
      preload_pkg::ST_START:
      begin
        next_s.load_start = 1'h1;
        next_s.load_done = 1'h0;
        next_s.words_seen = 8'h00;
        for (int i = 0; i < NUM_LINK_PORTS; i++)
          next_s.link_word[i] = `LINK_WORD_RST;
        next_s.st = preload_pkg::ST_LOAD;
      end
      preload_pkg::ST_LOAD:
      begin
        if (word_in.valid)
        begin
          next_s.words_seen = s.words_seen + 8'h01;
          if (word_in.addr == `WADDR_LINK_P0)
            next_s.link_word[0] = word_in.data;
          if (word_in.addr == `WADDR_LINK_P1)
            next_s.link_word[1] = word_in.data;
        end
        // release training only after the last word
        if (load_end)
        begin
          next_s.load_done = 1'h1;
          next_s.st = preload_pkg::ST_DONE;
        end
      end
      preload_pkg::ST_DONE:
      begin
        // reload is refused while a load runs, so a load is never restarted before its last word
        if (reload_wr)
        begin
          next_s.load_done = 1'h0;
          next_s.st = preload_pkg::ST_START;
        end
      end
    endcase

    if (paddr[11:4] == `APB_IMG78 >> 4)
      rd = img78(phy_cfg[idx]);
    else if (paddr[11:4] == `APB_IMG68 >> 4)
      rd = img68(phy_cfg[idx]);
    else if (paddr[11:4] == `APB_IMG_PM >> 4)
      rd = paddr[3] ? img33c(link_cfg[idx[0]]) : img98(link_cfg[idx[0]]);
    else if (paddr[11:2] == `APB_STATUS >> 2)
    begin
      rd[`STAT_DONE] = s.load_done;
      rd[`STAT_BUSY] = s.st != preload_pkg::ST_DONE;
      rd[`STAT_COUNT] = s.words_seen;
    end
    else if (paddr[11:2] != `APB_CTRL >> 2)
      err = 1'h1;

    // access phase answers one cycle after penable rises
    if (psel && penable && !s.pready)
    begin
      next_s.pready = 1'h1;
      next_s.prdata = pwrite ? 32'h0000_0000 : rd;
      next_s.pslverr = err;
    end
    else
    begin
      next_s.pready = 1'h0;
      next_s.prdata = 32'h0000_0000;
      next_s.pslverr = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_s)
  begin
    if (!rst_s)
    begin
      s.st <= preload_pkg::ST_START;
      s.link_word <= {NUM_LINK_PORTS{`LINK_WORD_RST}};
      s.words_seen <= 8'h00;
      s.load_start <= 1'h0;
      s.load_done <= 1'h0;
      s.pready <= 1'h0;
      s.pslverr <= 1'h0;
      s.prdata <= 32'h0000_0000;
    end
    else
      s <= next_s;
  end

  assign load_start = s.load_start;
  assign load_done = s.load_done;
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;

  // readback images of the power-management words, watched by the checks below
  logic [31:0] pm_img0;
  logic [31:0] pm_img1;
  assign pm_img0 = img98(link_cfg[0]);
  assign pm_img1 = img98(link_cfg[1]);

  sequence s_last_word;
    loading && load_end;
  endsequence

  sequence s_restart;
    s.st == preload_pkg::ST_START;
  endsequence

  // port 0 control from word 28h
  a_ltssm_p0: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h28
      |=> link_cfg[0].ltssm_ctl == $past(word_in.data[7:0]))
    else $error("port 0 training control not loaded");
  // port 1 control from word 2Ah
  a_ltssm_p1: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h2A
      |=> link_cfg[1].ltssm_ctl == $past(word_in.data[7:0]))
    else $error("port 1 training control not loaded");
  a_link_default: assert property (@(posedge clk) disable iff (!rst_s)
    s_restart |=> link_cfg[0] == '0 && link_cfg[1] == '0)
    else $error("link words not at default after restart");
  a_l1_option: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h28
      |=> pm_img0[24] == $past(word_in.data[12]))
    else $error("L1 option not at bit 24");
  a_l1_opt_p1: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h2A
      |=> pm_img1[24] == $past(word_in.data[12]))
    else $error("port 1 L1 option not at bit 24");
  a_l1_off: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h2A
      |=> pm_img1[25] == $past(word_in.data[13]))
    else $error("L1 off not at bit 25");
  a_clkreq_ctl: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h28
      |=> pm_img0[27:26] == $past(word_in.data[15:14]))
    else $error("clock request not at bits 27:26");
  a_clkreq_p1: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h2A
      |=> pm_img1[27:26] == $past(word_in.data[15:14]))
    else $error("port 1 clock request not at bits 27:26");
  a_restart_fts: assert property (@(posedge clk) disable iff (!rst_s)
    s_restart |=> phy_cfg[3].fts == 8'h80 && phy_cfg[3].speed_en == 1'b0)
    else $error("port 3 count not at default after restart");
  // load runs until its last word
  a_load_holds: assert property (@(posedge clk) disable iff (!rst_s)
    loading && !load_end |=> loading)
    else $error("load left before its last word");
  // word 20h feeds port 0, not port 1
  a_port0_word: assert property (@(posedge clk) disable iff (!rst_s)
    loading && word_in.valid && word_in.addr == 8'h20
      |=> phy_cfg[0].fts == $past(word_in.data[7:0]) && $stable(phy_cfg[1]))
    else $error("word 20h not routed to port 0");
  // done follows the last word by one edge
  a_done_after_end: assert property (@(posedge clk) disable iff (!rst_s)
    s_last_word |=> load_done ##1 (load_done || $past(reload_wr)))
    else $error("load done not raised after last word");
  // done never without a last word
  a_done_cause: assert property (@(posedge clk) disable iff (!rst_s)
    $rose(load_done) |-> $past(loading && load_end))
    else $error("load done without end of load");
  // fields frozen while training may run
  a_frozen_done: assert property (@(posedge clk) disable iff (!rst_s)
    load_done && !reload_wr |=> $stable(phy_cfg) && $stable(link_cfg))
    else $error("fields changed after load done");
  a_restart_req: assert property (@(posedge clk) disable iff (!rst_s)
    s_restart |=> load_start && !load_done ##1 !load_start)
    else $error("restart did not pulse load start");

endmodule // port_phy_link_config_preload
`default_nettype wire

// ==== pkg/preload_regs.svh ====
/*
  Constants of the boot-time port configuration loader: source word addresses,
  default words, source and destination field positions, and the APB map.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef PRELOAD_REGS_SVH
`define PRELOAD_REGS_SVH

// word addresses in the configuration memory
`define WADDR_PHY_P0 8'h20
`define WADDR_PHY_STEP 8'h02
`define WADDR_LINK_P0 8'h28
`define WADDR_LINK_P1 8'h2A

// values held while no loaded word overwrites them
`define PHY_WORD_RST 16'h0080
`define LINK_WORD_RST 16'h0000

// port configuration offsets that the fields land in
`define CFG_OFS_PHY 12'h078
`define CFG_OFS_DESKEW 12'h068
`define CFG_OFS_PM 12'h098
`define CFG_OFS_LTSSM 12'h33C

// fields of the fast-training word
`define SW_FTS 7:0
`define SW_DESKEW 9:8
`define SW_SCR 11:10
`define SW_L0S 12
`define SW_SPD_SEL 14:13
`define SW_SPD_EN 15

// fields of the link-training word
`define SW_LTSSM 7:0
`define SW_L1_OPT 12
`define SW_L1_OFF 13
`define SW_CLKREQ 15:14

// destination bits inside the port configuration registers
`define D78_FTS 7:0
`define D78_SCR 9:8
`define D78_L0S 10
`define D78_SPD_SEL 13:12
`define D78_SPD_EN 14
`define D68_DESKEW 14:13
`define D98_L1_OPT 24
`define D98_L1_OFF 25
`define D98_CLKREQ 27:26
`define D33C_LTSSM 7:0

// APB byte offsets and register bit positions
`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define APB_IMG78 12'h010
`define APB_IMG68 12'h020
`define APB_IMG_PM 12'h030
`define CTRL_RELOAD 0
`define STAT_DONE 0
`define STAT_BUSY 1
`define STAT_COUNT 15:8

`endif

// ==== pkg/preload_pkg.sv ====
/*
  Types of the port configuration loader: field carriers and loader states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package preload_pkg;

  typedef struct packed {
    logic [7:0] fts;
    logic [1:0] deskew;
    logic [1:0] scrambler;
    logic l0s;
    logic [1:0] speed_sel;
    logic speed_en;
  } phy_cfg_s;

  typedef struct packed {
    logic [7:0] ltssm_ctl;
    logic l1_power_mgmt_option;
    logic l1_power_mgmt_off;
    logic [1:0] clkreq_ctl;
  } link_cfg_s;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [15:0] data;
  } cfg_word_s;

  typedef enum logic [1:0] {
    ST_START,
    ST_LOAD,
    ST_DONE
  } load_state_e;

endpackage
`default_nettype wire

// ==== src/reset_release.sv ====
/*
  Reset release: asserts asynchronously, releases through two flip-flops.
  Assumes rst_n may change at any time relative to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module reset_release
(
  input wire logic clk,
  input wire logic rst_n,
  output logic rst_n_sync
);

  logic [1:0] stage;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stage <= 2'h0;
    else
      stage <= {stage[0], 1'h1};
  end

  assign rst_n_sync = stage[1];

endmodule // reset_release
`default_nettype wire

// ==== src/port_phy_fields.sv ====
/*
  One port's fast-training word and the physical-layer fields scattered from it.
  Assumes wr_en and clear come from logic on clk, and rst_n is already released
  synchronously.
*/
`timescale 1ns/10ps
`default_nettype none
`include "preload_regs.svh"
module port_phy_fields
#(
  parameter logic [15:0] RST_WORD = `PHY_WORD_RST
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output preload_pkg::phy_cfg_s cfg
);

  typedef struct packed {
    logic [15:0] word;
  } state_s;

  state_s s;
  state_s next_s;

  // default until a word is loaded
  always_comb
  begin
    next_s = s;
    if (clear)
      next_s.word = RST_WORD;
    else if (wr_en)
      next_s.word = wr_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '{word: RST_WORD};
    else
      s <= next_s;
  end

  assign cfg.fts = s.word[`SW_FTS];
  assign cfg.deskew = s.word[`SW_DESKEW];
  assign cfg.scrambler = s.word[`SW_SCR];
  assign cfg.l0s = s.word[`SW_L0S];
  assign cfg.speed_sel = s.word[`SW_SPD_SEL];
  assign cfg.speed_en = s.word[`SW_SPD_EN];

  a_default_word: assert property (@(posedge clk) disable iff (!rst_n)
    clear |=> {cfg.speed_en, cfg.speed_sel, cfg.l0s, cfg.scrambler, cfg.deskew, cfg.fts}
      == RST_WORD)
    else $error("cleared port fields not at default");
  a_fts_copy: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !clear |=> cfg.fts == $past(wr_data[7:0]))
    else $error("fast-training count not copied");
  a_deskew_copy: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !clear |=> cfg.deskew == $past(wr_data[9:8]))
    else $error("deskew mode not copied");
  a_scr_copy: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !clear |=> cfg.scrambler == $past(wr_data[11:10]))
    else $error("scrambler control not copied");
  a_l0s_copy: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !clear |=> cfg.l0s == $past(wr_data[12]))
    else $error("standby bit not copied");
  a_spd_sel_copy: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !clear |=> cfg.speed_sel == $past(wr_data[14:13]))
    else $error("speed select not copied");
  a_spd_en_copy: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !clear |=> cfg.speed_en == $past(wr_data[15]))
    else $error("speed enable not copied");
  a_fields_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en && !clear |=> $stable(cfg))
    else $error("port fields changed without a write");

endmodule // port_phy_fields
`default_nettype wire

// ==== verification/eeprom_word_source.sv ====
/*
  Model of the configuration memory reader: on a load request it sends
  the first count words of its image from address 20h upward, gap idle cycles
  between words, then pulses load_end.
  Assumes the loader samples its words on the rising edge of clk.
*/
`timescale 1ns/10ps
`default_nettype none
module eeprom_word_source
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_start,
  input wire logic [3:0] gap,
  input wire logic [2:0] count,
  input wire logic [5:0][15:0] img,
  output preload_pkg::cfg_word_s word_out,
  output logic load_end
);
  logic busy;
  logic [2:0] idx;
  logic [3:0] wait_cnt;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      idx <= 3'h0;
      wait_cnt <= 4'h0;
      word_out <= '0;
      load_end <= 1'b0;
    end
    else if (load_start)
    begin
      busy <= 1'b1;
      idx <= 3'h0;
      wait_cnt <= gap;
      load_end <= 1'b0;
      word_out <= {1'b0, ~word_out.addr, ~word_out.data};
    end
    else if (busy && wait_cnt == 4'h0 && idx != count)
    begin
      word_out <= {1'b1, 8'h20 + {4'h0, idx, 1'b0}, img[idx]};
      idx <= idx + 3'h1;
      wait_cnt <= gap;
      load_end <= 1'b0;
    end
    else
    begin
      // idle lines do not hold the last word
      word_out <= {1'b0, ~word_out.addr, ~word_out.data};
      // the last word is out once the gap after it has run down
      load_end <= busy && wait_cnt == 4'h0;
      if (busy && wait_cnt == 4'h0)
        busy <= 1'b0;
      if (wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule // eeprom_word_source
`default_nettype wire

// ==== verification/port_phy_link_config_preload_bench.sv ====
/*
  Self-checking bench of the port configuration loader with a memory model.
  Assumes a 25 MHz clock and the APB map of the loader.
*/
`timescale 1ns/10ps
`default_nettype none
module port_phy_link_config_preload_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] gap = 4'h3;
  logic [2:0] count = 3'h1;
  logic [5:0][15:0] img = {16'hB6E1, 16'h5A3C, 16'h9D48, 16'h7C21, 16'hE3B7, 16'hA5C3};
  preload_pkg::cfg_word_s word_in;
  logic load_end, load_start, load_done, pready, pslverr;
  logic [31:0] prdata;
  preload_pkg::phy_cfg_s [3:0] phy_cfg;
  preload_pkg::link_cfg_s [1:0] link_cfg;
  int n_fail = 0;
  int cmp_count = 0;

  port_phy_link_config_preload i_dut (.clk(clk), .rst_n(rst_n), .word_in(word_in),
    .load_end(load_end), .load_start(load_start), .load_done(load_done), .phy_cfg(phy_cfg),
    .link_cfg(link_cfg), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  eeprom_word_source i_mem (.clk(clk), .rst_n(rst_n), .load_start(load_start), .gap(gap),
    .count(count), .img(img), .word_out(word_in), .load_end(load_end));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [15:0] phy_exp(input logic [15:0] w);
    return {w[7:0], w[9:8], w[11:10], w[12], w[14:13], w[15]};
  endfunction

  function automatic logic [11:0] link_exp(input logic [15:0] w);
    return {w[7:0], w[12], w[13], w[15:14]};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // read at the edge: pready and prdata still hold what that edge samples
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk("apb answer cycles", 32'(n), 32'h2);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (load_done !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk("load_done", 32'(load_done), 32'h1);
  endtask

  task automatic check_defaults;
    chk("load_done reset", 32'(load_done), 32'h0);
    for (int p = 0; p < 4; p++)
      chk("phy default", 32'(phy_cfg[p]), 32'(phy_exp(16'h0080)));
    for (int p = 0; p < 2; p++)
      chk("link default", 32'(link_cfg[p]), 32'h0);
  endtask

  task automatic first_load;
    wait_done();
    chk("phy port0", 32'(phy_cfg[0]), 32'(phy_exp(img[0])));
    for (int p = 1; p < 4; p++)
      chk("phy unloaded", 32'(phy_cfg[p]), 32'(phy_exp(16'h0080)));
    chk("link unloaded", 32'(link_cfg[0]), 32'h0);
  endtask

  task automatic reload_full;
    logic [31:0] r;
    logic e;
    logic [15:0] w;
    @(posedge clk);
    count <= 3'h6;
    gap <= 4'h0;
    apb(1'b1, 12'h000, 32'h1, r, e);
    @(posedge clk);
    chk("load_done reload", 32'(load_done), 32'h0);
    @(posedge clk);
    chk("load_start pulse", 32'(load_start), 32'h1);
    chk("phy cleared", 32'(phy_cfg[0]), 32'(phy_exp(16'h0080)));
    chk("link cleared", 32'(link_cfg[0]), 32'h0);
    wait_done();
    for (int p = 0; p < 4; p++)
    begin
      w = img[p];
      chk("phy port", 32'(phy_cfg[p]), 32'(phy_exp(w)));
      apb(1'b0, 12'(16 + 4 * p), 32'h0, r, e);
      chk("img 78h", r, {17'h0, w[15], w[14:13], 1'b0, w[12], w[11:10], w[7:0]});
      apb(1'b0, 12'(32 + 4 * p), 32'h0, r, e);
      chk("img 68h", r, {17'h0, w[9:8], 13'h0});
    end
    for (int p = 0; p < 2; p++)
    begin
      w = img[4 + p];
      chk("link port", 32'(link_cfg[p]), 32'(link_exp(w)));
      apb(1'b0, 12'(48 + 4 * p), 32'h0, r, e);
      chk("img 98h", r, {4'h0, w[15:12], 24'h0});
      apb(1'b0, 12'(56 + 4 * p), 32'h0, r, e);
      chk("img 33Ch", r, {24'h0, w[7:0]});
    end
    // six words seen, done set, no longer busy
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("status", r, 32'h0000_0601);
    chk("status err", 32'(e), 32'h0);
  endtask

  task automatic bad_addr;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h040, 32'h0, r, e);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    check_defaults();
    rst_n <= 1'b1;
    first_load();
    reload_full();
    bad_addr();
    complete_run();
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule // port_phy_link_config_preload_bench
`default_nettype wire
